// ---- rtl/icsf_flags.sv ----
// Input capture status flags with register port and interrupts
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "icsf_defs.svh"
module icsf_flags
	import icsf_pkg::*;
(
	input wire logic i_clk, // Block clock, 125 MHz
	input wire logic i_reset, // Async reset, high
	input wire logic [`ICSF_ADDR_W-1:0] i_addr, // Register address
	input wire logic [`ICSF_DATA_W-1:0] i_wdata, // Register write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	output logic [`ICSF_DATA_W-1:0] o_rdata, // Read data, cycle after strobe
	input wire logic [`ICSF_DATA_W-1:0] i_frc_value, // Free running counter value
	input wire logic i_capture_pin_a, // Capture pin a
	input wire logic i_capture_pin_b, // Capture pin b
	input wire logic i_capture_pin_c, // Capture pin c
	output logic o_capture_irq_a, // Capture interrupt a request
	output logic o_capture_irq_b, // Capture interrupt b request
	output logic o_capture_irq_c, // Capture interrupt c request
	output logic o_irq // Event interrupt, level
);

	// ****************************************
	// Helpers
	// ****************************************

	// Address match for one register
	function automatic logic reg_hit(input logic [`ICSF_ADDR_W-1:0] addr,
		input logic [`ICSF_ADDR_W-1:0] off);
		reg_hit = (addr == off);
	endfunction : reg_hit

	// Status bit position of a channel's flag
	function automatic int flag_pos(input int ch);
		unique case (ch)
			0: flag_pos = `ICSF_BIT_FLAG_A;
			1: flag_pos = `ICSF_BIT_FLAG_B;
			default: flag_pos = `ICSF_BIT_FLAG_C;
		endcase
	endfunction : flag_pos

	// ****************************************
	// Pin synchronisers and edge detectors
	// ****************************************
	logic [2:0] pins;
	logic [2:0] cap_pulse;
	icsf_state_t s_q;
	icsf_state_t s_d;

	assign pins = {i_capture_pin_c, i_capture_pin_b, i_capture_pin_a};

	// One synchroniser per capture pin
	genvar g;
	generate
		for (g = 0; g < `ICSF_NCH; g++) begin : g_pin
			icsf_edge_sync u_edge (
				.i_clk(i_clk),
				.i_reset(i_reset),
				.i_pin(pins[g]),
				.i_rising_sel(s_q.edge_sel[g]),
				.o_pulse(cap_pulse[g])
			);
		end
	endgenerate

	// ****************************************
	// Capture register bank
	// ****************************************
	icsf_cap_if cap_bus ();

	// Every pulse loads; the bank applies the buffer modes
	assign cap_bus.load = cap_pulse;
	assign cap_bus.buf_a = s_q.buf_a;
	assign cap_bus.buf_b = s_q.buf_b;
	assign cap_bus.free_running_counter = i_frc_value;

	icsf_capture_bank u_bank (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.cap(cap_bus.ctrl)
	);

	// ****************************************
	// Register decode and flag logic
	// ****************************************
	logic tcs_wr;
	logic tcs_rd;
	logic [2:0] clr_flag;
	logic [2:0] overrun;
	logic [5:0] events;
	logic [7:0] tcs_val;

	always_comb begin
		s_d = s_q;
		s_d.rdata = '0;
		tcs_wr = i_wr && reg_hit(i_addr, `ICSF_OFF_TCS);
		tcs_rd = i_rd && reg_hit(i_addr, `ICSF_OFF_TCS);
		tcs_val = 8'h00;
		clr_flag = 3'h0;
		overrun = 3'h0;
		for (int i = 0; i < `ICSF_NCH; i++) begin
			tcs_val[flag_pos(i)] = s_q.flag[i];
			// Zero write clears only a flag that a read saw set
			clr_flag[i] = tcs_wr && !i_wdata[flag_pos(i)] && s_q.armed[i];
			overrun[i] = cap_pulse[i] && s_q.flag[i] && !clr_flag[i];
		end
		// Capture sets its flag in any mode; set wins over clear
		s_d.flag = (s_q.flag & ~clr_flag) | cap_pulse;
		// A read arms the flags it sees set; a status write disarms unless a status read comes in the same cycle
		if (tcs_rd) begin
			s_d.armed = s_q.flag;
		end else if (tcs_wr) begin
			s_d.armed = 3'h0;
		end
		// Control and enable registers
		if (i_wr && reg_hit(i_addr, `ICSF_OFF_CTRL)) begin
			s_d.edge_sel = {i_wdata[`ICSF_BIT_FLAG_C], i_wdata[`ICSF_BIT_FLAG_B],
				i_wdata[`ICSF_BIT_FLAG_A]};
			s_d.buf_a = i_wdata[`ICSF_BIT_BUF_A];
			s_d.buf_b = i_wdata[`ICSF_BIT_BUF_B];
		end
		if (i_wr && reg_hit(i_addr, `ICSF_OFF_IEN)) begin
			s_d.irq_en = {i_wdata[`ICSF_BIT_FLAG_C], i_wdata[`ICSF_BIT_FLAG_B],
				i_wdata[`ICSF_BIT_FLAG_A]};
		end
		if (i_wr && reg_hit(i_addr, `ICSF_OFF_EVEN)) begin
			s_d.ev_en = i_wdata[5:0];
		end
		// Sticky events: captures and captures onto a set flag
		events = {overrun, cap_pulse};
		if (i_wr && reg_hit(i_addr, `ICSF_OFF_EVCLR)) begin
			s_d.ev_st = (s_q.ev_st & ~i_wdata[5:0]) | events;
		end else begin
			s_d.ev_st = s_q.ev_st | events;
		end
		// Read data for the next cycle only
		if (i_rd) begin
			case (i_addr)
				`ICSF_OFF_TCS: s_d.rdata = {8'h00, tcs_val};
				`ICSF_OFF_CTRL: s_d.rdata = {8'h00, s_q.edge_sel[0], s_q.edge_sel[1],
					s_q.edge_sel[2], 3'h0, s_q.buf_a, s_q.buf_b};
				`ICSF_OFF_IEN: s_d.rdata = {8'h00, s_q.irq_en[0], s_q.irq_en[1],
					s_q.irq_en[2], 5'h00};
				`ICSF_OFF_EVST: s_d.rdata = {10'h000, s_q.ev_st};
				`ICSF_OFF_EVEN: s_d.rdata = {10'h000, s_q.ev_en};
				`ICSF_OFF_CAPA: s_d.rdata = cap_bus.cap[0];
				`ICSF_OFF_CAPB: s_d.rdata = cap_bus.cap[1];
				`ICSF_OFF_CAPC: s_d.rdata = cap_bus.cap[2];
				`ICSF_OFF_CAPD: s_d.rdata = cap_bus.cap[3];
				default: s_d.rdata = '0;
			endcase
		end
	end

	// State register
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign o_rdata = s_q.rdata;
	// Capture requests follow flag and enable, in buffer mode too
	assign o_capture_irq_a = s_q.flag[0] & s_q.irq_en[0];
	assign o_capture_irq_b = s_q.flag[1] & s_q.irq_en[1];
	assign o_capture_irq_c = s_q.flag[2] & s_q.irq_en[2];
	assign o_irq = |(s_q.ev_st & s_q.ev_en);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	sequence seen_a_s;
		tcs_rd && s_q.flag[0];
	endsequence

	sequence zero_a_s;
		tcs_wr && !i_wdata[`ICSF_BIT_FLAG_A] && !cap_pulse[0];
	endsequence

	sequence seen_c_s;
		tcs_rd && s_q.flag[2];
	endsequence

	sequence zero_c_s;
		tcs_wr && !i_wdata[`ICSF_BIT_FLAG_C] && !cap_pulse[2];
	endsequence

	flag_a_set_a: assert property (cap_pulse[0] |=> s_q.flag[0]) else $error("flag a not set");
	flag_b_set_a: assert property (cap_pulse[1] |=> s_q.flag[1]) else $error("flag b not set");
	flag_c_set_a: assert property (cap_pulse[2] && !s_q.buf_a |=> s_q.flag[2] && s_q.ev_st[2]) else $error("flag c not set");
	flag_c_buf_a: assert property (cap_pulse[2] && s_q.buf_a |=> s_q.flag[2]) else $error("flag c not set in buffer mode");
	// Read, one idle bus cycle, then the zero write
	clear_a_seq_a: assert property (seen_a_s ##1 (!i_rd && !i_wr) ##1 zero_a_s |=> !s_q.flag[0]) else $error("flag a not cleared");
	clear_c_seq_a: assert property (seen_c_s ##1 (!i_rd && !i_wr) ##1 zero_c_s |=> !s_q.flag[2]) else $error("flag c not cleared");
	one_write_b_a: assert property (tcs_wr && i_wdata[`ICSF_BIT_FLAG_B] && s_q.flag[1] |=> s_q.flag[1]) else $error("one write changed flag b");
	unread_clear_a: assert property (tcs_wr && s_q.flag[0] && !s_q.armed[0] |=> s_q.flag[0]) else $error("clear without read");
	set_wins_a: assert property (tcs_wr && s_q.armed[1] && cap_pulse[1] |=> s_q.flag[1]) else $error("set lost to clear");
	irq_c_rise_a: assert property (cap_pulse[2] && s_q.irq_en[2] && !(i_wr && reg_hit(i_addr, `ICSF_OFF_IEN)) |=> o_capture_irq_c) else $error("irq c not raised");
	irq_c_mask_a: assert property (!s_q.irq_en[2] |-> !o_capture_irq_c) else $error("irq c not suppressed");
	read_tcs_a: assert property (tcs_rd |=> o_rdata[`ICSF_BIT_FLAG_A] == $past(s_q.flag[0]) ##1 o_rdata == 16'h0000 || $past(i_rd)) else $error("status read wrong");

endmodule : icsf_flags

// ---- rtl/icsf_defs.svh ----
// Register offsets, field positions, reset values and widths of the capture flag block
`ifndef ICSF_DEFS_SVH
`define ICSF_DEFS_SVH

// ****************************************
// Widths
// ****************************************
`define ICSF_ADDR_W 4
`define ICSF_DATA_W 16
`define ICSF_NCH 3
`define ICSF_NEV 6

// ****************************************
// Register offsets
// ****************************************
`define ICSF_OFF_TCS 4'h0
`define ICSF_OFF_CTRL 4'h1
`define ICSF_OFF_IEN 4'h2
`define ICSF_OFF_EVST 4'h3
`define ICSF_OFF_EVCLR 4'h4
`define ICSF_OFF_EVEN 4'h5
`define ICSF_OFF_CAPA 4'h8
`define ICSF_OFF_CAPB 4'h9
`define ICSF_OFF_CAPC 4'hA
`define ICSF_OFF_CAPD 4'hB

// ****************************************
// Field positions
// ****************************************
`define ICSF_BIT_FLAG_A 7
`define ICSF_BIT_FLAG_B 6
`define ICSF_BIT_FLAG_C 5
`define ICSF_BIT_BUF_A 1
`define ICSF_BIT_BUF_B 0

// ****************************************
// Reset values
// ****************************************
`define ICSF_RST_CAP 16'h0000

`endif

// ---- rtl/icsf_pkg.sv ----
// Types shared by the capture flag block
package icsf_pkg;

	typedef logic [15:0] icsf_word_t;

	// Main block state
	typedef struct packed {
		logic [2:0] flag;
		logic [2:0] armed;
		logic [2:0] edge_sel;
		logic buf_a;
		logic buf_b;
		logic [2:0] irq_en;
		logic [5:0] ev_st;
		logic [5:0] ev_en;
		icsf_word_t rdata;
	} icsf_state_t;

	// Capture register bank state, index 0..3 = a..d
	typedef struct packed {
		icsf_word_t [3:0] cap;
	} icsf_bank_t;

	// Pin synchroniser and edge detector state
	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
		logic pulse;
	} icsf_edge_t;

endpackage : icsf_pkg

// ---- rtl/icsf_cap_if.sv ----
// Carrier between flag logic and capture register bank
`timescale 1ns/100ps
`include "icsf_defs.svh"
interface icsf_cap_if;
	logic [2:0] load;
	logic buf_a;
	logic buf_b;
	logic [`ICSF_DATA_W-1:0] free_running_counter;
	logic [3:0][`ICSF_DATA_W-1:0] cap;

	modport ctrl (output load, output buf_a, output buf_b, output free_running_counter, input cap);
	modport bank (input load, input buf_a, input buf_b, input free_running_counter, output cap);
endinterface : icsf_cap_if

// ---- rtl/icsf_edge_sync.sv ----
// Two-flop pin synchroniser with selectable edge detector
`timescale 1ns/100ps
module icsf_edge_sync
	import icsf_pkg::*;
(
	input wire logic i_clk, // Block clock
	input wire logic i_reset, // Async reset, high
	input wire logic i_pin, // Asynchronous capture pin
	input wire logic i_rising_sel, // 1 rising edge, 0 falling edge
	output logic o_pulse // One-cycle edge pulse
);

	icsf_edge_t s_q;
	icsf_edge_t s_d;

	// Next state: meta feeds only sync
	always_comb begin
		s_d = s_q;
		s_d.meta = i_pin;
		s_d.sync = s_q.meta;
		s_d.prev = s_q.sync;
		s_d.pulse = i_rising_sel ? (s_q.sync & ~s_q.prev) : (~s_q.sync & s_q.prev);
	end

	// State register
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_pulse = s_q.pulse;

endmodule : icsf_edge_sync

// ---- rtl/icsf_capture_bank.sv ----
// Capture registers a to d with buffer-mode moves
`timescale 1ns/100ps
`include "icsf_defs.svh"
module icsf_capture_bank
	import icsf_pkg::*;
(
	input wire logic i_clk, // Block clock
	input wire logic i_reset, // Async reset, high
	icsf_cap_if.bank cap // Load strobes, modes and captured words
);

	icsf_bank_t s_q;
	icsf_bank_t s_d;

	// Capture and buffer moves
	always_comb begin
		s_d = s_q;
		if (cap.load[0]) begin
			if (cap.buf_a) begin
				s_d.cap[2] = s_q.cap[0];
			end
			s_d.cap[0] = cap.free_running_counter;
		end
		if (cap.load[1]) begin
			if (cap.buf_b) begin
				s_d.cap[3] = s_q.cap[1];
			end
			s_d.cap[1] = cap.free_running_counter;
		end
		// Pin c only loads its register outside buffer mode a
		if (cap.load[2] && !cap.buf_a) begin
			s_d.cap[2] = cap.free_running_counter;
		end
	end

	// State register
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			s_q.cap <= {4{`ICSF_RST_CAP}};
		end else begin
			s_q <= s_d;
		end
	end

	assign cap.cap = s_q.cap;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	sequence buf_a_load_s;
		cap.load[0] && cap.buf_a;
	endsequence

	buf_a_move_a: assert property (buf_a_load_s |=> (s_q.cap[2] == $past(s_q.cap[0])) && (s_q.cap[0] == $past(cap.free_running_counter))) else $error("buffer a move wrong");
	buf_b_move_a: assert property (cap.load[1] && cap.buf_b |=> (s_q.cap[3] == $past(s_q.cap[1])) && (s_q.cap[1] == $past(cap.free_running_counter))) else $error("buffer b move wrong");
	cap_c_load_a: assert property (cap.load[2] && !cap.buf_a |=> s_q.cap[2] == $past(cap.free_running_counter)) else $error("register c not loaded");
	cap_c_hold_a: assert property (cap.load[2] && cap.buf_a && !cap.load[0] |=> $stable(s_q.cap[2])) else $error("register c written in buffer mode");

endmodule : icsf_capture_bank

// ---- verification/icsf_pin_model.sv ----
// Capture pin sources standing on the far side of the flag block
`timescale 1ns/100ps
module icsf_pin_model (
	input wire logic i_clk, // Block clock
	input wire logic i_reset, // Async reset, high
	input wire logic [2:0] i_fire, // One pulse request per channel
	output logic [2:0] o_pin // Capture pins a, b, c
);
	logic [2:0][2:0] cnt_q;

	// Each request holds the pin high for seven cycles, long enough for the synchroniser
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			cnt_q <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (i_fire[i]) begin
					cnt_q[i] <= 3'h7;
				end else if (cnt_q[i] != 3'h0) begin
					cnt_q[i] <= cnt_q[i] - 3'h1;
				end
			end
		end
	end

	// Pin level follows the hold counter
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			o_pin[i] = (cnt_q[i] != 3'h0);
		end
	end
endmodule : icsf_pin_model

// ---- verification/input_capture_status_flags_bench.sv ----
// Self-checking bench for the capture flag block
`timescale 1ns/100ps
`include "icsf_defs.svh"
module input_capture_status_flags_bench;
	import icsf_pkg::*;
	logic i_clk, i_reset, i_wr, i_rd, o_irq;
	logic [3:0] i_addr;
	logic [2:0] fire, pin, irq;
	icsf_word_t i_wdata, i_frc_value, o_rdata, got;
	int n_errors, n_tests, cyc, f, arm, ev, ien, een, bufa, bufb;
	int cap[4];

	icsf_flags dut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_frc_value(i_frc_value),
		.i_capture_pin_a(pin[0]), .i_capture_pin_b(pin[1]), .i_capture_pin_c(pin[2]),
		.o_capture_irq_a(irq[0]), .o_capture_irq_b(irq[1]), .o_capture_irq_c(irq[2]),
		.o_irq(o_irq));
	icsf_pin_model pm (.i_clk(i_clk), .i_reset(i_reset), .i_fire(fire), .o_pin(pin));

	// ****************************************
	// Clock, timeout and verdict
	// ****************************************
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	// Cut a hang short well after the expected run length
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("errors %0d of %0d checks", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : print_verdict

	// ****************************************
	// Bus tasks and model
	// ****************************************
	task automatic check(input string nm, input icsf_word_t exp, input icsf_word_t seen);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [3:0] a, input icsf_word_t d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output icsf_word_t d);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask : rd

	// Status read arms the clear of every flag it saw set
	task automatic rst();
		rd(4'h0, got);
		check("status", 16'((f & 1) << 7 | (f & 2) << 5 | (f & 4) << 3), got);
		check("capture irq", 16'(f & ien), {13'h0000, irq});
		check("event irq", 16'((ev & een) != 0), {15'h0000, o_irq});
		arm = f;
	endtask : rst

	// Zero bits clear armed flags only; any status write disarms
	task automatic wst(input icsf_word_t d);
		int dm;
		dm = d[7] | d[6] << 1 | d[5] << 2;
		wr(4'h0, d);
		f = f & ~(arm & ~dm);
		arm = 0;
	endtask : wst

	task automatic fire_ch(input int ch);
		@(posedge i_clk);
		i_frc_value <= 16'($urandom);
		fire <= 3'h1 << ch;
		@(posedge i_clk);
		fire <= 3'h0;
		repeat (12) @(posedge i_clk);
		if (ch == 0 && bufa != 0) cap[2] = cap[0];
		if (ch == 1 && bufb != 0) cap[3] = cap[1];
		if (ch != 2 || bufa == 0) cap[ch] = i_frc_value;
		if ((f >> ch) & 1) ev = ev | (8 << ch);
		ev = ev | (1 << ch);
		f = f | (1 << ch);
	endtask : fire_ch

	task automatic chk_caps();
		for (int i = 0; i < 4; i++) begin
			rd(4'(8 + i), got);
			check("capture reg", 16'(cap[i]), got);
		end
	endtask : chk_caps

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		i_reset = 1'b1;
		{i_wr, i_rd, i_addr, i_wdata, i_frc_value, fire} = '0;
		{n_errors, n_tests, cyc, f, arm, ev, ien, een, bufa, bufb} = '0;
		cap = '{0, 0, 0, 0};
		void'($urandom(62));
		repeat (4) @(posedge i_clk);
		i_reset <= 1'b0;
		rst();
		chk_caps();
		rd(4'hF, got);
		check("unmapped", 16'h0000, got);
		wr(4'h1, 16'h00E0);
		wr(4'h2, 16'h00E0);
		ien = 7;
		wr(4'h5, 16'h0001);
		een = 1;
		for (int ch = 0; ch < 3; ch++) begin
			fire_ch(ch);
			rst();
			chk_caps();
		end
		wst(16'h00C0);
		rst();
		wst(16'h00C0);
		wst(16'h0000);
		rst();
		wst(16'h0000);
		rst();
		wr(4'h2, 16'h0000);
		ien = 0;
		fire_ch(2);
		rst();
		wr(4'h2, 16'h00E0);
		ien = 7;
		wr(4'h1, 16'h00E3);
		bufa = 1;
		bufb = 1;
		for (int ch = 0; ch < 3; ch++) begin
			fire_ch(ch);
		end
		fire_ch(0);
		rst();
		chk_caps();
		rd(4'h3, got);
		check("event status", 16'(ev), got);
		wr(4'h5, 16'h0000);
		een = 0;
		rst();
		wr(4'h5, 16'h0001);
		een = 1;
		wr(4'h4, 16'h003F);
		ev = 0;
		rst();
		rd(4'h3, got);
		check("event status", 16'(ev), got);
		print_verdict();
	end
endmodule : input_capture_status_flags_bench
